// *** common/pcb_consts.svh ***
// command codes, special cycle fields and decode timing of the claim logic
`ifndef PCB_CONSTS_SVH
`define PCB_CONSTS_SVH
`define PCB_CMD_SPECIAL 4'h1
`define PCB_CMD_IORD 4'h2
`define PCB_CMD_IOWR 4'h3
`define PCB_CMD_MEMRD 4'h6
`define PCB_CMD_MEMWR 4'h7
`define PCB_CMD_CFGRD 4'hA
`define PCB_CMD_CFGWR 4'hB
`define PCB_CMD_MRM 4'hC
`define PCB_CMD_MRL 4'hE
`define PCB_CMD_MWI 4'hF
`define PCB_CFG_TYPE0 2'h0
`define PCB_CFG_TYPE1 2'h1
`define PCB_SPC_DEVICE 5'h1F
`define PCB_SPC_FUNCTION 3'h7
`define PCB_DECODE_LAST 2'h1
`define PCB_PRI_SYNC_IDLE 42'h200_0000_0001
`define PCB_SEC_SYNC_IDLE 41'h100_0000_0000
`endif

// *** common/pcb_pkg.sv ***
// state and answer types of the claim logic
package pcb_pkg;
  typedef enum logic [1:0] {TGT_IDLE = 2'b00, TGT_WAIT = 2'b01, TGT_RESP = 2'b10} pcb_tgt_t;
  typedef enum logic [1:0] {ENG_IDLE = 2'b00, ENG_RUN = 2'b01, ENG_HELD = 2'b10} pcb_eng_t;
  typedef enum logic [1:0] {ANS_NORMAL = 2'b01, ANS_RETRY = 2'b10} pcb_ans_t;
endpackage

// *** src/pcb_claim_forward.sv ***
// claim, retry and forwarding decisions of a two-port pci bridge
// Functional notes
// RULE1: secondary config read, type 0 write: ignore
// RULE2: secondary type 1 non-special write: ignore
// RULE3: special request to primary bus: special cycle
// RULE4: special request outside all buses: forward type1
// RULE5: special request inside secondary range: ignore
// RULE6: masters begin every cycle by asserting frame
// RULE7: primary local target: stay silent, watch select
// RULE8: primary to secondary: claim, complete or retry
// RULE9: run downstream, hold result until repeated
// RULE10: primary cycle to nowhere: leave unclaimed
// RULE11: secondary local or unknown target: stay silent
// RULE12: secondary to primary: claim, complete or retry
// RULE13: run upstream, finish when initiator repeats
// RULE14: retried initiator repeats identical command, address
`timescale 1ns/100ps
`include "pcb_consts.svh"
module pcb_claim_forward
  import pcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bridge bus numbers and downstream memory and io window
  input wire logic [7:0] primaryBus,
  input wire logic [7:0] secondaryBus,
  input wire logic [7:0] subordinateBus,
  input wire logic [31:0] windowBase,
  input wire logic [31:0] windowLimit,
  // primary bus pins
  input wire logic priFrameN,
  input wire logic [3:0] priCmd,
  input wire logic [31:0] priAddr,
  input wire logic [3:0] priBe,
  input wire logic priOtherSelN,
  // primary target answer
  output logic primary_device_select_n,
  output logic priTrdyN,
  output logic priStopN,
  // secondary bus pins
  input wire logic secFrameN,
  input wire logic [3:0] secCmd,
  input wire logic [31:0] secAddr,
  input wire logic [3:0] secBe,
  // secondary target answer
  output logic secondary_device_select_n,
  output logic secTrdyN,
  output logic secStopN,
  // request to the secondary master
  output logic dnReqValid,
  output logic [3:0] dnReqCmd,
  output logic [31:0] dnReqAddr,
  output logic [3:0] dnReqBe,
  input wire logic dnReqDone,
  // request to the primary master
  output logic upReqValid,
  output logic [3:0] upReqCmd,
  output logic [31:0] upReqAddr,
  output logic [3:0] upReqBe,
  input wire logic upReqDone
);

  function automatic logic inWin(input logic [31:0] a, input logic [31:0] b,
                                 input logic [31:0] l);
    inWin = (a >= b) && (a <= l);
  endfunction

  function automatic logic isMemIo(input logic [3:0] c);
    case (c)
      `PCB_CMD_IORD, `PCB_CMD_IOWR, `PCB_CMD_MEMRD, `PCB_CMD_MEMWR,
      `PCB_CMD_MRM, `PCB_CMD_MRL, `PCB_CMD_MWI: isMemIo = 1'b1;
      default: isMemIo = 1'b0;
    endcase
  endfunction

  // only memory writes may be posted; everything else is a delayed cycle
  function automatic logic isPostable(input logic [3:0] c);
    isPostable = (c == `PCB_CMD_MEMWR) || (c == `PCB_CMD_MWI);
  endfunction

  function automatic logic sameReq(input logic [3:0] c1, input logic [31:0] a1,
                                   input logic [3:0] b1, input logic [3:0] c2,
                                   input logic [31:0] a2, input logic [3:0] b2);
    sameReq = (c1 == c2) && (a1 == a2) && (b1 == b2);
  endfunction

  logic [41:0] priSync1_r;
  logic [41:0] priSync2_r;
  logic [40:0] secSync1_r;
  logic [40:0] secSync2_r;
  logic priFrameDly_r;
  logic secFrameDly_r;

  // pins from both buses pass two flops before any decision looks at them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      priSync1_r <= `PCB_PRI_SYNC_IDLE;
      priSync2_r <= `PCB_PRI_SYNC_IDLE;
      secSync1_r <= `PCB_SEC_SYNC_IDLE;
      secSync2_r <= `PCB_SEC_SYNC_IDLE;
      priFrameDly_r <= 1'b1;
      secFrameDly_r <= 1'b1;
    end else begin
      priSync1_r <= {priFrameN, priCmd, priAddr, priBe, priOtherSelN};
      priSync2_r <= priSync1_r;
      secSync1_r <= {secFrameN, secCmd, secAddr, secBe};
      secSync2_r <= secSync1_r;
      priFrameDly_r <= priSync2_r[41];
      secFrameDly_r <= secSync2_r[40];
    end
  end

  logic pFrame;
  logic [3:0] pCmd;
  logic [31:0] pAddr;
  logic [3:0] pBe;
  logic pOtherSel;
  logic sFrame;
  logic [3:0] sCmd;
  logic [31:0] sAddr;
  logic [3:0] sBe;
  assign {pFrame, pCmd, pAddr, pBe, pOtherSel} = priSync2_r;
  assign {sFrame, sCmd, sAddr, sBe} = secSync2_r;

  // a cycle starts only on the falling edge of frame (see RULE6)
  logic priStart;
  logic secStart;
  assign priStart = priFrameDly_r && !pFrame;
  assign secStart = secFrameDly_r && !sFrame;

  pcb_tgt_t pState_r;
  pcb_tgt_t sState_r;
  pcb_eng_t dnState_r;
  pcb_eng_t upState_r;
  logic [1:0] pCnt_r;
  logic [3:0] pCmd_r;
  logic [31:0] pAddr_r;
  logic [3:0] pBe_r;
  logic dnPosted_r;
  logic upPosted_r;
  logic [3:0] dnCmd_r;
  logic [31:0] dnAddr_r;
  logic [3:0] dnBe_r;
  logic [3:0] upCmd_r;
  logic [3:0] upOutCmd_r;
  logic [31:0] upAddr_r;
  logic [3:0] upBe_r;
  logic dnValid_r;
  logic upValid_r;
  logic priSel_r;
  logic priTrdy_r;
  logic priStop_r;
  logic secSel_r;
  logic secTrdy_r;
  logic secStop_r;

  // secondary decode
  logic cfgType1;
  logic special;
  logic [7:0] tBus;
  logic inRange;
  logic secHit;
  logic [3:0] secFwdCmd;
  assign cfgType1 = (sCmd == `PCB_CMD_CFGWR) && (sAddr[1:0] == `PCB_CFG_TYPE1);
  assign special = cfgType1 && (sAddr[15:11] == `PCB_SPC_DEVICE) &&
                   (sAddr[10:8] == `PCB_SPC_FUNCTION);
  assign tBus = sAddr[23:16];
  assign inRange = (tBus >= secondaryBus) && (tBus <= subordinateBus);
  // memory and io cycles outside the window are taken as upstream; config reads,
  // type 0 and plain type 1 writes never hit (see RULE1) (see RULE2)
  assign secHit = (isMemIo(sCmd) && !inWin(sAddr, windowBase, windowLimit)) || // see RULE11
                  (special && ((tBus == primaryBus) || !inRange)); // see RULE5
  assign secFwdCmd = (tBus == primaryBus) ? `PCB_CMD_SPECIAL : sCmd; // see RULE3

  // answers: one slot per direction, a busy slot retries everyone else
  logic priDecide;
  logic dnStart;
  logic dnRelease;
  logic secDecide;
  logic upStart;
  logic upRelease;
  pcb_ans_t priAns;
  pcb_ans_t secAns;
  assign priDecide = (pState_r == TGT_WAIT) && pOtherSel && !pFrame &&
                     (pCnt_r == `PCB_DECODE_LAST);
  assign dnStart = priDecide && (dnState_r == ENG_IDLE);
  assign dnRelease = priDecide && (dnState_r == ENG_HELD) && // see RULE14
                     sameReq(pCmd_r, pAddr_r, pBe_r, dnCmd_r, dnAddr_r, dnBe_r);
  assign secDecide = (sState_r == TGT_IDLE) && secStart && secHit;
  assign upStart = secDecide && (upState_r == ENG_IDLE);
  assign upRelease = secDecide && (upState_r == ENG_HELD) &&
                     sameReq(sCmd, sAddr, sBe, upCmd_r, upAddr_r, upBe_r);

  always_comb begin
    priAns = ANS_RETRY;
    if ((dnStart && isPostable(pCmd_r)) || dnRelease) begin
      priAns = ANS_NORMAL; // see RULE8
    end
    secAns = ANS_RETRY;
    if ((upStart && isPostable(sCmd) && !special) || upRelease) begin
      secAns = ANS_NORMAL; // see RULE12
    end
  end

  // primary target: waits two clocks so fast and medium local targets win
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pState_r <= TGT_IDLE;
      pCnt_r <= 2'h0;
      pCmd_r <= 4'h0;
      pAddr_r <= 32'h0000_0000;
      pBe_r <= 4'h0;
      priSel_r <= 1'b1;
      priTrdy_r <= 1'b1;
      priStop_r <= 1'b1;
    end else begin
      case (pState_r)
        TGT_IDLE: begin
          if (priStart && isMemIo(pCmd) && inWin(pAddr, windowBase, windowLimit)) begin
            pState_r <= TGT_WAIT; // see RULE10
            pCnt_r <= 2'h0;
            pCmd_r <= pCmd;
            pAddr_r <= pAddr;
            pBe_r <= pBe;
          end
        end
        TGT_WAIT: begin
          pCnt_r <= pCnt_r + 2'h1;
          if (!pOtherSel || pFrame) begin
            pState_r <= TGT_IDLE; // see RULE7
          end else if (priDecide) begin
            pState_r <= TGT_RESP;
            priSel_r <= 1'b0; // see RULE8
            priTrdy_r <= (priAns != ANS_NORMAL);
            priStop_r <= (priAns != ANS_RETRY);
          end
        end
        TGT_RESP: begin
          if (pFrame) begin
            pState_r <= TGT_IDLE;
            priSel_r <= 1'b1;
            priTrdy_r <= 1'b1;
            priStop_r <= 1'b1;
          end
        end
        default: pState_r <= TGT_IDLE;
      endcase
    end
  end

  // secondary target: positive decode, answers at the start of the cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sState_r <= TGT_IDLE;
      secSel_r <= 1'b1;
      secTrdy_r <= 1'b1;
      secStop_r <= 1'b1;
    end else begin
      case (sState_r)
        TGT_IDLE: begin
          if (secDecide) begin
            sState_r <= TGT_RESP;
            secSel_r <= 1'b0; // see RULE12
            secTrdy_r <= (secAns != ANS_NORMAL);
            secStop_r <= (secAns != ANS_RETRY);
          end
        end
        TGT_RESP: begin
          if (sFrame) begin
            sState_r <= TGT_IDLE;
            secSel_r <= 1'b1;
            secTrdy_r <= 1'b1;
            secStop_r <= 1'b1;
          end
        end
        default: sState_r <= TGT_IDLE;
      endcase
    end
  end

  // downstream slot: posted writes free it on completion, others hold it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dnState_r <= ENG_IDLE;
      dnValid_r <= 1'b0;
      dnPosted_r <= 1'b0;
      dnCmd_r <= 4'h0;
      dnAddr_r <= 32'h0000_0000;
      dnBe_r <= 4'h0;
    end else begin
      case (dnState_r)
        ENG_IDLE: begin
          if (dnStart) begin
            dnState_r <= ENG_RUN; // see RULE9
            dnValid_r <= 1'b1;
            dnPosted_r <= isPostable(pCmd_r);
            dnCmd_r <= pCmd_r;
            dnAddr_r <= pAddr_r;
            dnBe_r <= pBe_r;
          end
        end
        ENG_RUN: begin
          if (dnReqDone) begin
            dnValid_r <= 1'b0;
            dnState_r <= dnPosted_r ? ENG_IDLE : ENG_HELD; // see RULE9
          end
        end
        ENG_HELD: begin
          if (dnRelease) begin
            dnState_r <= ENG_IDLE;
          end
        end
        default: dnState_r <= ENG_IDLE;
      endcase
    end
  end

  // upstream slot: keeps the original command for matching the repeat
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upState_r <= ENG_IDLE;
      upValid_r <= 1'b0;
      upPosted_r <= 1'b0;
      upCmd_r <= 4'h0;
      upOutCmd_r <= 4'h0;
      upAddr_r <= 32'h0000_0000;
      upBe_r <= 4'h0;
    end else begin
      case (upState_r)
        ENG_IDLE: begin
          if (upStart) begin
            upState_r <= ENG_RUN; // see RULE13
            upValid_r <= 1'b1;
            upPosted_r <= isPostable(sCmd) && !special;
            upCmd_r <= sCmd;
            upOutCmd_r <= special ? secFwdCmd : sCmd; // see RULE4
            upAddr_r <= sAddr;
            upBe_r <= sBe;
          end
        end
        ENG_RUN: begin
          if (upReqDone) begin
            upValid_r <= 1'b0;
            upState_r <= upPosted_r ? ENG_IDLE : ENG_HELD; // see RULE13
          end
        end
        ENG_HELD: begin
          if (upRelease) begin
            upState_r <= ENG_IDLE;
          end
        end
        default: upState_r <= ENG_IDLE;
      endcase
    end
  end

  assign primary_device_select_n = priSel_r;
  assign priTrdyN = priTrdy_r;
  assign priStopN = priStop_r;
  assign secondary_device_select_n = secSel_r;
  assign secTrdyN = secTrdy_r;
  assign secStopN = secStop_r;
  assign dnReqValid = dnValid_r;
  assign dnReqCmd = dnCmd_r;
  assign dnReqAddr = dnAddr_r;
  assign dnReqBe = dnBe_r;
  assign upReqValid = upValid_r;
  assign upReqCmd = upOutCmd_r;
  assign upReqAddr = upAddr_r;
  assign upReqBe = upBe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sec_cfg_ignore_a: assert property ( // see RULE1
    secStart && ((sCmd == `PCB_CMD_CFGRD) || ((sCmd == `PCB_CMD_CFGWR) &&
    (sAddr[1:0] == `PCB_CFG_TYPE0))) |=> secondary_device_select_n ##1 !upReqValid ||
    $past(upReqValid, 2))
    else $error("secondary config read or type 0 write was claimed");
  type1_ignore_a: assert property ( // see RULE2
    secStart && cfgType1 && !special |=> secondary_device_select_n)
    else $error("plain type 1 write was claimed");
  special_primary_a: assert property ( // see RULE3
    secStart && special && (tBus == primaryBus) && (upState_r == ENG_IDLE) |=>
    upReqValid && (upReqCmd == `PCB_CMD_SPECIAL) && !secondary_device_select_n)
    else $error("special request to primary bus not issued as special cycle");
  special_forward_a: assert property ( // see RULE4
    secStart && special && (tBus != primaryBus) && !inRange && (upState_r == ENG_IDLE) |=>
    upReqValid && (upReqCmd == `PCB_CMD_CFGWR) && (upReqAddr == $past(sAddr)))
    else $error("special request not forwarded unchanged");
  special_local_a: assert property ( // see RULE5
    secStart && special && (tBus != primaryBus) && inRange |=> secondary_device_select_n)
    else $error("special request inside secondary range was claimed");
  pri_local_a: assert property ( // see RULE7
    (pState_r == TGT_WAIT) && !pOtherSel |=> (pState_r == TGT_IDLE) && primary_device_select_n)
    else $error("bridge answered a cycle already taken on primary");
  pri_claim_a: assert property ( // see RULE8
    priDecide |=> !primary_device_select_n && (priTrdyN != priStopN))
    else $error("primary claim without a single normal or retry answer");
  pri_hold_a: assert property ( // see RULE9
    (dnState_r == ENG_RUN) && dnReqDone && !dnPosted_r |=> (dnState_r == ENG_HELD) &&
    !dnReqValid)
    else $error("delayed downstream result not held");
  pri_nowhere_a: assert property ( // see RULE10
    priStart && !inWin(pAddr, windowBase, windowLimit) && (pState_r == TGT_IDLE) |=>
    (pState_r == TGT_IDLE) [*2])
    else $error("primary cycle outside the window was decoded");
  sec_local_a: assert property ( // see RULE11
    secStart && !special && inWin(sAddr, windowBase, windowLimit) |=> secondary_device_select_n)
    else $error("secondary local cycle was claimed");
  sec_claim_a: assert property ( // see RULE12
    secDecide |=> !secondary_device_select_n && (secTrdyN != secStopN))
    else $error("secondary claim without a single normal or retry answer");
  up_repeat_a: assert property ( // see RULE13
    upRelease |=> (upState_r == ENG_IDLE) && !secTrdyN && secStopN)
    else $error("repeated upstream cycle not finished normally");

  posted_down_c: cover property (dnStart && isPostable(pCmd_r) ##[1:50] dnReqDone);
  delayed_down_c: cover property ((dnState_r == ENG_HELD) ##[1:100] dnRelease);
  special_up_c: cover property (upStart && special);
  delayed_up_c: cover property ((upState_r == ENG_HELD) ##[1:100] upRelease);

endmodule

// *** tb/pcb_claim_forward_bench.sv ***
// self-checking bench of the bridge claim and forwarding logic
`timescale 1ns/100ps
module pcb_claim_forward_bench;
  import pcb_pkg::*;
  localparam logic [7:0] PRI = 8'h02;
  localparam logic [7:0] SEC = 8'h05;
  localparam logic [7:0] SUB = 8'h09;
  localparam logic [31:0] WBASE = 32'h1000_0000;
  localparam logic [31:0] WLIM = 32'h1FFF_FFFF;
  localparam logic [3:0] CMDS [7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
  localparam logic [7:0] BUSES [6] = '{PRI, SEC, SUB, 8'h04, 8'h0A, 8'hFF};
  logic clk = 1'b0;
  logic resetN = 1'b0;
  logic priFrameN = 1'b1, priOtherSelN = 1'b1, secFrameN = 1'b1;
  logic [3:0] priCmd = 4'h0, priBe = 4'h0, secCmd = 4'h0, secBe = 4'h0;
  logic [31:0] priAddr = 32'h0, secAddr = 32'h0;
  logic priSelN, priTrdyN, priStopN, secSelN, secTrdyN, secStopN;
  logic dnReqValid, dnReqDone, upReqValid, upReqDone;
  logic [3:0] dnReqCmd, dnReqBe, upReqCmd, upReqBe;
  logic [31:0] dnReqAddr, upReqAddr;
  int dnLag = 1, upLag = 1;
  int miscompares = 0, checkCount = 0;
  int slotSt [2], startCnt [2], doneCnt [2];
  logic [3:0] slotCmd [2], slotBe [2], fwdCmd [2];
  logic [31:0] slotAddr [2];
  logic slotPost [2];
  logic newSlot;

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (dnReqDone === 1'b1) doneCnt[0]++;
    if (upReqDone === 1'b1) doneCnt[1]++;
  end

  pcb_claim_forward uut (.clk, .reset_n(resetN), .primaryBus(PRI), .secondaryBus(SEC),
    .subordinateBus(SUB), .windowBase(WBASE), .windowLimit(WLIM), .priFrameN, .priCmd,
    .priAddr, .priBe, .priOtherSelN, .primary_device_select_n(priSelN), .priTrdyN,
    .priStopN, .secFrameN, .secCmd, .secAddr, .secBe, .secondary_device_select_n(secSelN),
    .secTrdyN, .secStopN, .dnReqValid, .dnReqCmd, .dnReqAddr, .dnReqBe, .dnReqDone,
    .upReqValid, .upReqCmd, .upReqAddr, .upReqBe, .upReqDone);
  pcb_far_side dnFar (.clk, .reset_n(resetN), .reqValid(dnReqValid), .lag(dnLag),
    .reqDone(dnReqDone));
  pcb_far_side upFar (.clk, .reset_n(resetN), .reqValid(upReqValid), .lag(upLag),
    .reqDone(upReqDone));

  function automatic logic [31:0] inW();
    return {4'h1, 28'($urandom)};
  endfunction
  function automatic logic [31:0] outW();
    return {4'h8, 28'($urandom)};
  endfunction
  function automatic logic [31:0] spc(input logic [7:0] bus);
    return {8'h00, bus, 5'h1F, 3'h7, 6'($urandom), 2'h1};
  endfunction

  // 0 silent, 1 normal, 2 retry, 3 malformed answer
  function automatic int answer(input int s);
    logic [2:0] v;
    v = s ? {secSelN, secTrdyN, secStopN} : {priSelN, priTrdyN, priStopN};
    if (v === 3'b111) return 0;
    if (v === 3'b001) return 1;
    if (v === 3'b010) return 2;
    return 3;
  endfunction

  // s 0: primary master, downstream slot; s 1: secondary master, upstream slot
  function automatic int decide(input int s, input logic [3:0] c, input logic [31:0] a,
      input logic [3:0] b, input logic sel);
    logic hit;
    hit = 1'b0;
    if (c inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF})
      hit = (a >= WBASE && a <= WLIM) ? (s == 0 && sel) : (s == 1);
    else if (s == 1 && c == 4'hB && a[1:0] == 2'h1 && a[15:8] == 8'hFF)
      hit = a[23:16] == PRI || a[23:16] < SEC || a[23:16] > SUB;
    if (!hit) return 0;
    if (slotSt[s] == 2 && {slotCmd[s], slotAddr[s], slotBe[s]} === {c, a, b}) begin
      slotSt[s] = 0;
      return 1;
    end
    if (slotSt[s] != 0) return 2;
    slotSt[s] = 1;
    {slotCmd[s], slotAddr[s], slotBe[s]} = {c, a, b};
    slotPost[s] = c == 4'h7 || c == 4'hF;
    fwdCmd[s] = (c == 4'hB && a[23:16] == PRI) ? 4'h1 : c;
    startCnt[s] = doneCnt[s];
    newSlot = 1'b1;
    return slotPost[s] ? 1 : 2;
  endfunction

  task automatic checkAns(input int got, input int exp);
    checkCount++;
    if (got != exp) begin
      miscompares++;
      $display("unexpected answer at %0t: got %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic checkFwd(input int s);
    logic [39:0] got;
    got = s ? {upReqCmd, upReqAddr, upReqBe} : {dnReqCmd, dnReqAddr, dnReqBe};
    checkCount++;
    if (got !== {fwdCmd[s], slotAddr[s], slotBe[s]}) begin
      miscompares++;
      $display("unexpected forward at %0t: got %h side %0d", $time, got, s);
    end
  endtask

  task automatic runCycle(input int s, input logic [3:0] c, input logic [31:0] a,
      input logic [3:0] b, input logic sel);
    int exp, got, other, n;
    newSlot = 1'b0;
    exp = decide(s, c, a, b, sel);
    got = 0;
    other = 0;
    if (s == 0) {priCmd, priAddr, priBe, priOtherSelN, priFrameN} = {c, a, b, sel, 1'b0};
    else {secCmd, secAddr, secBe, secFrameN} = {c, a, b, 1'b0};
    for (n = 0; n < 12 && got == 0; n++) begin
      @(negedge clk);
      got = answer(s);
      other = other | answer(1 - s);
    end
    checkAns(got, exp);
    checkAns(other, 0);
    {priFrameN, secFrameN, priOtherSelN} = 3'b111;
    for (n = 0; n < 10 && (answer(0) | answer(1)) != 0; n++) @(negedge clk);
    checkAns(answer(0) | answer(1), 0);
    repeat (4) @(negedge clk);
  endtask

  task automatic drain(input int s);
    int n;
    for (n = 0; n < 300 && doneCnt[s] == startCnt[s]; n++) @(negedge clk);
    @(negedge clk);
    checkAns(doneCnt[s] - startCnt[s], 1);
    checkFwd(s);
    slotSt[s] = slotPost[s] ? 0 : 2;
  endtask

  // a retried initiator always comes back with the identical cycle
  task automatic full(input int s, input logic [3:0] c, input logic [31:0] a,
      input logic [3:0] b, input logic sel);
    runCycle(s, c, a, b, sel);
    if (newSlot) begin
      drain(s);
      if (slotSt[s] == 2) runCycle(s, c, a, b, sel);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] a;
    int i;
    void'($urandom(32'h97940a6b));
    repeat (12) @(negedge clk);
    resetN = 1'b1;
    full(1, 4'hA, spc(PRI), 4'hF, 1'b1);
    full(1, 4'hB, spc(PRI) & 32'hFFFF_FFFC, 4'h0, 1'b1);
    full(1, 4'hB, {8'h00, 8'h40, 5'h0E, 3'h7, 8'h01}, 4'h0, 1'b1);
    full(1, 4'hB, {8'h00, 8'h40, 5'h1F, 3'h6, 8'h01}, 4'h0, 1'b1);
    full(0, 4'hB, spc(8'h40), 4'h0, 1'b1);
    full(0, 4'h6, inW(), 4'h0, 1'b0);
    full(0, 4'h6, WBASE - 32'h1, 4'h0, 1'b1);
    full(1, 4'h6, WLIM, 4'h0, 1'b1);
    $display("test ignored cycles done");
    foreach (BUSES[k]) full(1, 4'hB, spc(BUSES[k]), 4'($urandom), 1'b1);
    $display("test special requests done");
    full(0, 4'h6, WLIM, 4'h5, 1'b1);
    foreach (CMDS[k]) begin
      full(0, CMDS[k], inW(), 4'($urandom), 1'b1);
      full(1, CMDS[k], outW(), 4'($urandom), 1'b1);
    end
    $display("test command set done");
    dnLag = 200;
    a = inW();
    runCycle(0, 4'h6, a, 4'h3, 1'b1);
    runCycle(0, 4'h7, inW(), 4'h0, 1'b1);
    runCycle(0, 4'h6, a, 4'h3, 1'b1);
    drain(0);
    runCycle(0, 4'h6, a, 4'h1, 1'b1);
    runCycle(0, 4'h6, a, 4'h3, 1'b1);
    dnLag = 1;
    a = spc(PRI);
    runCycle(1, 4'hB, a, 4'h0, 1'b1);
    drain(1);
    // a reset drops the held result, so the repeat starts over
    resetN = 1'b0;
    repeat (2) @(negedge clk);
    resetN = 1'b1;
    slotSt = '{0, 0};
    full(1, 4'hB, a, 4'h0, 1'b1);
    $display("test busy and mismatch done");
    for (i = 0; i < 24; i++) begin
      a = ($urandom % 2) ? inW() : outW();
      full(i % 2, CMDS[$urandom % 7], a, 4'($urandom), 1'($urandom % 4 != 0));
    end
    $display("test random traffic done");
    closeOut();
  end

  // the whole run needs well under ten thousand cycles
  initial begin
    #400000;
    miscompares++;
    $display("unexpected hang at %0t: watchdog expired", $time);
    closeOut();
  end
endmodule

// *** tb/pcb_far_side.sv ***
// far-side bus master model that completes forwarded requests after a set lag
`timescale 1ns/100ps
module pcb_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request from the bridge, and the completion lag set by the bench
  input wire logic reqValid,
  input wire logic [31:0] lag,
  // completion back to the bridge
  output logic reqDone
);
  int cnt;

  // done is a single pulse; the count restarts so a dropping valid never sees a second one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      reqDone <= 1'b0;
    end else begin
      reqDone <= 1'b0;
      if (!reqValid || reqDone) begin
        cnt <= 0;
      end else if (cnt + 1 >= lag) begin
        reqDone <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
